// >>> atpf_formatter.sv
`timescale 1ns/100ps
module atpf_formatter (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic bus_reset_i,
    output logic [31:0] tx_quad_o,
    output logic tx_valid_o,
    output logic tx_last_o,
    output logic [1:0] tx_speed_o,
    output logic tx_priority_arb_o
);
    typedef enum logic [2:0] {ST_HDR, ST_Q2, ST_Q3, ST_Q4, ST_PAY} atpf_state_t;

    logic rst_n;
    logic [2:0] brst_reg, brst_next;
    logic flush_reg, flush_next;
    logic drop_reg, drop_next;
    atpf_state_t state_reg, state_next;
    atpf_pkg::atpf_fmt_t fmt_reg, fmt_next;
    logic [31:0] hdr_reg, hdr_next;
    logic [31:0] dest_reg, dest_next;
    logic [31:0] offlo_reg, offlo_next;
    logic [31:0] q4_reg, q4_next;
    logic [13:0] remain_reg, remain_next;
    logic [15:0] sent_reg, sent_next;
    logic [15:0] dropped_reg, dropped_next;
    logic spd_err_reg, spd_err_next;
    logic [31:0] ctrl_reg, ctrl_next;
    logic [31:0] txq_reg, txq_next;
    logic txv_reg, txv_next;
    logic txl_reg, txl_next;
    logic [1:0] spd_reg, spd_next;
    logic pri_reg, pri_next;
    logic [31:0] rdata_reg, rdata_next;
    logic err_reg, err_next;
    logic wr_en, rd_en, is_fifo, is_last;
    logic ack_reg, ack_next;

    atpf_reset_sync u_rst (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .rst_n_o(rst_n)
    );

    localparam logic [3:0] TC_WR_QUAD_L = atpf_pkg::TC_WR_QUAD;
    localparam logic [3:0] TC_WR_BLOCK_L = atpf_pkg::TC_WR_BLOCK;
    localparam logic [3:0] TC_WR_RESP_L = atpf_pkg::TC_WR_RESP;
    localparam logic [3:0] TC_RD_QUAD_L = atpf_pkg::TC_RD_QUAD;
    localparam logic [3:0] TC_RD_BLOCK_L = atpf_pkg::TC_RD_BLOCK;
    localparam logic [3:0] TC_RD_QRESP_L = atpf_pkg::TC_RD_QRESP;
    localparam logic [3:0] TC_RD_BRESP_L = atpf_pkg::TC_RD_BRESP;
    localparam logic [3:0] TC_LOCK_REQ_L = atpf_pkg::TC_LOCK_REQ;
    localparam logic [3:0] TC_LOCK_RESP_L = atpf_pkg::TC_LOCK_RESP;

    function automatic atpf_pkg::atpf_fmt_t fmt_of(input logic [3:0] tc);
        unique case (tc)
            TC_WR_RESP_L, TC_RD_QUAD_L: fmt_of = atpf_pkg::FMT_NODATA;
            TC_WR_QUAD_L, TC_RD_BLOCK_L, TC_RD_QRESP_L: fmt_of = atpf_pkg::FMT_QUAD;
            TC_WR_BLOCK_L, TC_RD_BRESP_L, TC_LOCK_REQ_L, TC_LOCK_RESP_L: begin
                fmt_of = atpf_pkg::FMT_BLOCK;
            end
            default: fmt_of = atpf_pkg::FMT_BAD;
        endcase
    endfunction

    // Bus reset is a pin: three-flop chain, acted on while stages 2 and 3 are both high
    assign brst_next = {brst_reg[1:0], bus_reset_i};

    assign is_fifo = (paddr_i == atpf_pkg::OFS_TX_NEXT) || (paddr_i == atpf_pkg::OFS_TX_LAST);
    assign is_last = (paddr_i == atpf_pkg::OFS_TX_LAST);
    // One wait state: reads are looked up in the first access cycle so the registered
    // data and error already stand at the pready edge; writes land at that edge
    assign wr_en = psel_i & penable_i & ack_reg & pwrite_i;
    assign rd_en = psel_i & penable_i & ~ack_reg & ~pwrite_i;
    assign pready_o = ack_reg;
    assign pslverr_o = err_reg;
    assign prdata_o = rdata_reg;
    assign tx_quad_o = txq_reg;
    assign tx_valid_o = txv_reg;
    assign tx_last_o = txl_reg;
    assign tx_speed_o = spd_reg;
    assign tx_priority_arb_o = pri_reg;

    always_comb begin
        state_next = state_reg;
        fmt_next = fmt_reg;
        hdr_next = hdr_reg;
        dest_next = dest_reg;
        offlo_next = offlo_reg;
        q4_next = q4_reg;
        remain_next = remain_reg;
        sent_next = sent_reg;
        dropped_next = dropped_reg;
        spd_err_next = spd_err_reg;
        ctrl_next = ctrl_reg;
        flush_next = flush_reg;
        drop_next = drop_reg;
        txq_next = txq_reg;
        txv_next = 1'b0;
        txl_next = 1'b0;
        spd_next = spd_reg;
        pri_next = pri_reg;
        rdata_next = 32'h0000_0000;
        err_next = 1'b0;
        ack_next = psel_i & penable_i & ~ack_reg;
        // Holding bus reset keeps flushing; the set wins over any resume header
        if (brst_reg[1] & brst_reg[2]) begin
            flush_next = 1'b1;
        end
        if (wr_en && paddr_i == atpf_pkg::OFS_CTRL) begin
            ctrl_next = pwdata_i;
            if (pwdata_i[0]) begin
                sent_next = 16'h0000;
                dropped_next = 16'h0000;
                spd_err_next = 1'b0;
            end
        end
        if (wr_en && is_fifo) begin
            unique case (state_reg)
                ST_HDR: begin
                    hdr_next = pwdata_i;
                    fmt_next = fmt_of(pwdata_i[atpf_pkg::TRANSACTION_CODE_LSB +: 4]);
                    // A resume header re-enables transmit and is itself sent
                    if (flush_reg && !pwdata_i[atpf_pkg::RESUME_BIT]) begin
                        drop_next = 1'b1;
                    end else begin
                        drop_next = 1'b0;
                        if (!(brst_reg[1] & brst_reg[2])) begin
                            flush_next = 1'b0;
                        end
                    end
                    state_next = ST_Q2;
                end
                ST_Q2: begin
                    dest_next = pwdata_i;
                    state_next = ST_Q3;
                end
                ST_Q3: begin
                    offlo_next = pwdata_i;
                    state_next = (fmt_reg == atpf_pkg::FMT_NODATA) ? ST_HDR : ST_Q4;
                end
                ST_Q4: begin
                    q4_next = pwdata_i;
                    // Length rounded up to whole quadlets; host supplies zero padding
                    remain_next = pwdata_i[atpf_pkg::LEN_LSB + 2 +: 14]
                        + 14'(pwdata_i[atpf_pkg::LEN_LSB +: 2] != 2'h0);
                    state_next = (fmt_reg == atpf_pkg::FMT_BLOCK && !is_last) ? ST_PAY : ST_HDR;
                end
                ST_PAY: begin
                    remain_next = remain_reg - 14'h1;
                    state_next = is_last ? ST_HDR : ST_PAY;
                end
                default: state_next = ST_HDR;
            endcase
            // Last-register write always closes the packet
            if (is_last) begin
                state_next = ST_HDR;
            end
            if (!drop_next) begin
                txq_next = pwdata_i;
                txv_next = 1'b1;
                txl_next = is_last;
                if (state_reg == ST_HDR) begin
                    spd_next = pwdata_i[atpf_pkg::SPD_LSB +: 2];
                    pri_next = pwdata_i[atpf_pkg::PRI_LSB +: 4] != 4'h0;
                    if (pwdata_i[atpf_pkg::SPD_LSB +: 2] == atpf_pkg::SPD_ILLEGAL) begin
                        spd_err_next = 1'b1;
                    end
                end
                if (is_last) begin
                    sent_next = sent_reg + 16'h1;
                end
            end else if (is_last) begin
                dropped_next = dropped_reg + 16'h1;
            end
        end
        if (rd_en) begin
            unique case (paddr_i)
                atpf_pkg::OFS_CTRL: rdata_next = ctrl_reg;
                atpf_pkg::OFS_STATUS: rdata_next = {24'h0, 1'b0, fmt_reg, state_reg,
                    drop_reg, flush_reg} | {2'h0, remain_reg, spd_err_reg, 15'h0};
                atpf_pkg::OFS_HDR0: rdata_next = hdr_reg;
                atpf_pkg::OFS_DEST: rdata_next = dest_reg;
                atpf_pkg::OFS_OFFS_LO: rdata_next = offlo_reg;
                atpf_pkg::OFS_QUAD4: rdata_next = q4_reg;
                atpf_pkg::OFS_COUNT: rdata_next = {dropped_reg, sent_reg};
                atpf_pkg::OFS_TX_NEXT, atpf_pkg::OFS_TX_LAST: rdata_next = 32'h0000_0000;
                default: err_next = 1'b1;
            endcase
        end
        if (psel_i && penable_i && !ack_reg && pwrite_i && !is_fifo
            && paddr_i != atpf_pkg::OFS_CTRL) begin
            err_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            brst_reg <= 3'h0;
            flush_reg <= 1'b0;
            drop_reg <= 1'b0;
            state_reg <= ST_HDR;
            fmt_reg <= atpf_pkg::FMT_NODATA;
            hdr_reg <= 32'h0000_0000;
            dest_reg <= 32'h0000_0000;
            offlo_reg <= 32'h0000_0000;
            q4_reg <= 32'h0000_0000;
            remain_reg <= 14'h0;
            sent_reg <= 16'h0;
            dropped_reg <= 16'h0;
            spd_err_reg <= 1'b0;
            ctrl_reg <= atpf_pkg::CTRL_RST;
            txq_reg <= 32'h0000_0000;
            txv_reg <= 1'b0;
            txl_reg <= 1'b0;
            spd_reg <= 2'h0;
            pri_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            err_reg <= 1'b0;
            ack_reg <= 1'b0;
        end else begin
            brst_reg <= brst_next;
            flush_reg <= flush_next;
            drop_reg <= drop_next;
            state_reg <= state_next;
            fmt_reg <= fmt_next;
            hdr_reg <= hdr_next;
            dest_reg <= dest_next;
            offlo_reg <= offlo_next;
            q4_reg <= q4_next;
            remain_reg <= remain_next;
            sent_reg <= sent_next;
            dropped_reg <= dropped_next;
            spd_err_reg <= spd_err_next;
            ctrl_reg <= ctrl_next;
            txq_reg <= txq_next;
            txv_reg <= txv_next;
            txl_reg <= txl_next;
            spd_reg <= spd_next;
            pri_reg <= pri_next;
            rdata_reg <= rdata_next;
            err_reg <= err_next;
            ack_reg <= ack_next;
        end
    end
endmodule

// >>> atpf_pkg.sv
package atpf_pkg;
    // APB register byte offsets
    localparam logic [7:0] OFS_TX_NEXT = 8'h00;
    localparam logic [7:0] OFS_TX_LAST = 8'h04;
    localparam logic [7:0] OFS_CTRL = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_HDR0 = 8'h10;
    localparam logic [7:0] OFS_DEST = 8'h14;
    localparam logic [7:0] OFS_OFFS_LO = 8'h18;
    localparam logic [7:0] OFS_QUAD4 = 8'h1c;
    localparam logic [7:0] OFS_COUNT = 8'h20;
    // First (header) quadlet field positions
    localparam int RESUME_BIT = 23;
    localparam int IMM_BIT = 22;
    localparam int SPD_LSB = 16;
    localparam int LABEL_LSB = 10;
    localparam int RETRY_LSB = 8;
    localparam int TRANSACTION_CODE_LSB = 4;
    localparam int PRI_LSB = 0;
    // Second quadlet field positions; LEN_LSB is in the fourth quadlet
    localparam int DEST_LSB = 16;
    localparam int RESPONSE_CODE_LSB = 12;
    localparam int LEN_LSB = 16;
    // Transaction codes
    localparam logic [3:0] TC_WR_QUAD = 4'h0;
    localparam logic [3:0] TC_WR_BLOCK = 4'h1;
    localparam logic [3:0] TC_WR_RESP = 4'h2;
    localparam logic [3:0] TC_RD_QUAD = 4'h4;
    localparam logic [3:0] TC_RD_BLOCK = 4'h5;
    localparam logic [3:0] TC_RD_QRESP = 4'h6;
    localparam logic [3:0] TC_RD_BRESP = 4'h7;
    localparam logic [3:0] TC_LOCK_REQ = 4'h9;
    localparam logic [3:0] TC_LOCK_RESP = 4'hb;
    localparam logic [1:0] SPD_ILLEGAL = 2'h3;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    typedef enum logic [1:0] {RATE_100, RATE_200, RATE_400, RATE_BAD} atpf_rate_t;
    typedef enum logic [1:0] {RETRY_1, RETRY_X, RETRY_A, RETRY_B} atpf_retry_t;
    typedef enum logic [1:0] {FMT_NODATA, FMT_QUAD, FMT_BLOCK, FMT_BAD} atpf_fmt_t;
endpackage

// >>> atpf_reset_sync.sv
`timescale 1ns/100ps
module atpf_reset_sync (
    input wire logic clk_i,
    input wire logic resetn_i,
    output logic rst_n_o
);
    logic [1:0] sync_reg;
    logic [1:0] sync_next;

    always_comb begin
        sync_next = {sync_reg[0], 1'b1};
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync_reg <= 2'h0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign rst_n_o = sync_reg[1];
endmodule

// >>> atpf_formatter_props.sv
`timescale 1ns/100ps
module atpf_formatter_props (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [31:0] tx_quad_o,
    input wire logic tx_valid_o,
    input wire logic tx_last_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    logic acc;
    logic txw;
    assign acc = psel_i && penable_i;
    assign txw = acc && pready_o && pwrite_i &&
        (paddr_i == atpf_pkg::OFS_TX_NEXT || paddr_i == atpf_pkg::OFS_TX_LAST);
    valid_source_a: assert property (tx_valid_o |-> $past(txw))
        else $error("Quadlet sent without a transmit write");
    quad_copy_a: assert property (tx_valid_o |-> tx_quad_o == $past(pwdata_i))
        else $error("Sent quadlet differs from written one");
    last_mark_a: assert property (tx_last_o |-> tx_valid_o &&
        $past(paddr_i) == atpf_pkg::OFS_TX_LAST) else $error("Last flag without last write");
    last_done_a: assert property (tx_valid_o &&
        $past(paddr_i) == atpf_pkg::OFS_TX_LAST |-> tx_last_o) else $error("Last flag missing");
    read_no_tx_a: assert property (acc && !pwrite_i |=> !tx_valid_o)
        else $error("Read access sent a quadlet");
    slverr_unmapped_a: assert property (acc && pready_o && paddr_i > atpf_pkg::OFS_COUNT
        |-> pslverr_o ##1 !tx_valid_o) else $error("Unmapped access not refused");
    mapped_ok_a: assert property (txw |-> !pslverr_o)
        else $error("Transmit write refused");
    prdata_idle_a: assert property (!(acc && pready_o) |-> prdata_o == 32'h0)
        else $error("Read data stands outside its cycle");
    ready_wait_a: assert property (acc && !pready_o |=> pready_o)
        else $error("Ready not given after one wait state");
    ready_gated_a: assert property (pready_o |-> $past(acc && !pready_o))
        else $error("Ready without a pending access");
    cover property (tx_last_o);
    cover property (txw && paddr_i == atpf_pkg::OFS_TX_LAST ##1 !tx_valid_o);
    cover property (acc && paddr_i > atpf_pkg::OFS_COUNT);
endmodule
bind atpf_formatter atpf_formatter_props props_u (.clk_i(clk_i), .resetn_i(resetn_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .tx_quad_o(tx_quad_o), .tx_valid_o(tx_valid_o), .tx_last_o(tx_last_o));

// >>> atpf_host_model.sv
`timescale 1ns/100ps
module atpf_host_model (
    input wire logic clk_i,
    input wire logic pready_i,
    input wire logic [31:0] prdata_i,
    input wire logic pslverr_i,
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [7:0] paddr_o,
    output logic [31:0] pwdata_o
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 8'h00;
        pwdata_o = 32'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic er);
        @(posedge clk_i);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        @(posedge clk_i);
        while (pready_i !== 1'b1) @(posedge clk_i);
        // Answer taken at the very edge where pready is seen high
        rd = prdata_i;
        er = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        // Released lines show garbage so stale values are never mistaken for data
        paddr_o <= ~a;
        pwdata_o <= ~d;
    endtask
endmodule

// >>> tb_async_tx_packet_formatter.sv
`timescale 1ns/100ps
`define ATPF_CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
    $display("Error at %0t: got %h exp %h", $time, g, e); end end
module tb_async_tx_packet_formatter;
    typedef struct {logic [7:0] a; logic [31:0] d; logic h;} atpf_row_t;
    localparam logic [7:0] NX = atpf_pkg::OFS_TX_NEXT;
    localparam logic [7:0] LS = atpf_pkg::OFS_TX_LAST;
    localparam logic [31:0] DST = {10'h00f, 6'h05, 16'h0000};
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic bus_reset_i = 1'b0;
    logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o, tx_valid_o, tx_last_o;
    logic tx_priority_arb_o;
    logic [1:0] tx_speed_o;
    logic [7:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, tx_quad_o;
    int num_errors = 0;
    int checks = 0;
    atpf_row_t rows [24];
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    atpf_formatter dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .bus_reset_i(bus_reset_i), .tx_quad_o(tx_quad_o), .tx_valid_o(tx_valid_o),
        .tx_last_o(tx_last_o), .tx_speed_o(tx_speed_o), .tx_priority_arb_o(tx_priority_arb_o));
    atpf_host_model host_u (.clk_i(clk_i), .pready_i(pready_o), .prdata_i(prdata_o),
        .pslverr_i(pslverr_o), .psel_o(psel_i),
        .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i));
    function automatic logic [31:0] hdr(input logic [1:0] sp, input logic [5:0] lb,
        input logic [1:0] rt, input logic [3:0] tc, input logic [3:0] pr);
        return (32'(sp) << atpf_pkg::SPD_LSB) | (32'(lb) << atpf_pkg::LABEL_LSB) |
            (32'(rt) << atpf_pkg::RETRY_LSB) | (32'(tc) << atpf_pkg::TRANSACTION_CODE_LSB) |
            (32'(pr) << atpf_pkg::PRI_LSB);
    endfunction
    task automatic close_out();
        $display("Checks %0d, errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic put(input atpf_row_t r, input logic ev);
        logic [31:0] rd;
        logic er;
        host_u.xfer(1'b1, r.a, r.d, rd, er);
        `ATPF_CHK(er, 1'b0)
        #1;
        `ATPF_CHK(tx_valid_o, ev)
        if (ev) begin
            `ATPF_CHK(tx_quad_o, r.d)
            `ATPF_CHK(tx_last_o, r.a == LS)
        end
        if (ev && r.h) begin
            `ATPF_CHK(tx_speed_o, r.d[atpf_pkg::SPD_LSB +: 2])
            `ATPF_CHK(tx_priority_arb_o, |r.d[atpf_pkg::PRI_LSB +: 4])
        end
    endtask
    initial begin
        #50000;
        num_errors++;
        close_out();
    end
    initial begin
        atpf_row_t r;
        logic [31:0] rd;
        logic er;
        // Retry codes and speeds all appear; labels differ per request
        rows = '{
            '{NX, hdr(2'h0, 6'h01, 2'h0, atpf_pkg::TC_RD_QUAD, 4'h0), 1'b1}, '{NX, DST, 1'b0},
            '{LS, 32'h0000_1000, 1'b0},
            '{NX, hdr(2'h1, 6'h02, 2'h1, atpf_pkg::TC_WR_QUAD, 4'h3), 1'b1}, '{NX, DST, 1'b0},
            '{NX, 32'h0000_2004, 1'b0}, '{LS, 32'hcafe_0001, 1'b0},
            '{NX, hdr(2'h2, 6'h03, 2'h2, atpf_pkg::TC_RD_BLOCK, 4'h0), 1'b1}, '{NX, DST, 1'b0},
            '{NX, 32'h0000_3008, 1'b0}, '{LS, {16'd64, 16'h0000}, 1'b0},
            '{NX, hdr(2'h2, 6'h04, 2'h3, atpf_pkg::TC_WR_BLOCK, 4'h0), 1'b1}, '{NX, DST, 1'b0},
            '{NX, 32'h0000_400c, 1'b0}, '{NX, {16'd6, 16'h0000}, 1'b0},
            '{NX, 32'h1122_3344, 1'b0}, '{LS, 32'h5566_0000, 1'b0},
            '{NX, hdr(2'h3, 6'h02, 2'h0, atpf_pkg::TC_WR_RESP, 4'h0), 1'b1},
            '{NX, DST | 32'h0000_4000, 1'b0}, '{LS, 32'h0000_0000, 1'b0},
            '{NX, hdr(2'h1, 6'h05, 2'h1, atpf_pkg::TC_LOCK_REQ, 4'h1), 1'b1}, '{NX, DST, 1'b0},
            '{NX, 32'h0000_5010, 1'b0}, '{LS, {16'd0, 16'h0002}, 1'b0}};
        repeat (4) @(posedge clk_i);
        `ATPF_CHK(tx_valid_o, 1'b0)
        resetn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        foreach (rows[i]) put(rows[i], 1'b1);
        host_u.xfer(1'b1, 8'h40, 32'h0, rd, er);
        #1;
        `ATPF_CHK(er, 1'b1)
        `ATPF_CHK(tx_valid_o, 1'b0)
        host_u.xfer(1'b0, atpf_pkg::OFS_CTRL, 32'h0, rd, er);
        `ATPF_CHK(rd, atpf_pkg::CTRL_RST)
        host_u.xfer(1'b0, atpf_pkg::OFS_COUNT, 32'h0, rd, er);
        `ATPF_CHK(rd, 32'h0000_0006)
        host_u.xfer(1'b0, atpf_pkg::OFS_STATUS, 32'h0, rd, er);
        `ATPF_CHK(rd[15], 1'b1)
        // Bit 0 of control clears the packet counters and the speed error
        host_u.xfer(1'b1, atpf_pkg::OFS_CTRL, 32'h5a5a_a5a5, rd, er);
        host_u.xfer(1'b0, atpf_pkg::OFS_CTRL, 32'h0, rd, er);
        `ATPF_CHK(rd, 32'h5a5a_a5a5)
        host_u.xfer(1'b0, atpf_pkg::OFS_COUNT, 32'h0, rd, er);
        `ATPF_CHK(rd, 32'h0000_0000)
        host_u.xfer(1'b0, atpf_pkg::OFS_STATUS, 32'h0, rd, er);
        `ATPF_CHK(rd[15], 1'b0)
        @(posedge clk_i);
        bus_reset_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        bus_reset_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        // Stale packet dropped, single resumed packet sent, then normal traffic
        for (int p = 0; p < 3; p++) begin
            for (int i = 0; i < 3; i++) begin
                r = rows[i];
                r.d[atpf_pkg::RESUME_BIT] = (i == 0 && p == 1);
                put(r, p != 0);
            end
        end
        host_u.xfer(1'b0, atpf_pkg::OFS_COUNT, 32'h0, rd, er);
        `ATPF_CHK(rd, 32'h0001_0002)
        // Reset in mid-packet starts the next packet from its header
        host_u.xfer(1'b1, NX, rows[3].d, rd, er);
        @(posedge clk_i);
        resetn_i <= 1'b0;
        #1;
        `ATPF_CHK(tx_valid_o, 1'b0)
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        for (int i = 0; i < 3; i++) put(rows[i], 1'b1);
        host_u.xfer(1'b0, atpf_pkg::OFS_HDR0, 32'h0, rd, er);
        `ATPF_CHK(rd, rows[0].d)
        host_u.xfer(1'b0, atpf_pkg::OFS_DEST, 32'h0, rd, er);
        `ATPF_CHK(rd, rows[1].d)
        close_out();
    end
endmodule
